// ==== logic/btc_defines.svh ====
// constants of the bit-test branch and cpu control execution unit
// assumes inclusion by bare name from btc_exec_core and the bench
`ifndef BTC_DEFINES_SVH
`define BTC_DEFINES_SVH

// ----------------------------------------------------------------
// register byte offsets (apb, one aligned word each)
// ----------------------------------------------------------------
`define BTC_OFS_INSTR 12'h000
`define BTC_OFS_PC 12'h004
`define BTC_OFS_REGS 12'h008
`define BTC_OFS_PTR 12'h00c
`define BTC_OFS_STAT 12'h010
`define BTC_OFS_WAKE 12'h014
`define BTC_OFS_MADDR 12'h018
`define BTC_OFS_MDATA 12'h01c
`define BTC_OFS_CLKSEL 12'h020

// ----------------------------------------------------------------
// field ranges
// ----------------------------------------------------------------
`define BTC_F_OP 3:0
`define BTC_F_KIND 6:4
`define BTC_F_BIT 10:8
`define BTC_F_DISP 23:16
`define BTC_F_SADDR 31:24
`define BTC_F_A 7:0
`define BTC_F_B 15:8
`define BTC_F_C 23:16
`define BTC_F_FLAGS 31:24
`define BTC_F_PTR 15:0
`define BTC_F_CLKSEL 2:0
`define BTC_F_CYC 11:8
`define BTC_B_BUSY 0
`define BTC_B_INTEN 1
`define BTC_B_HALT 2
`define BTC_B_STOP 3
`define BTC_B_TAKEN 4
`define BTC_B_FAST 5

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define BTC_RST_PC 16'h0000
`define BTC_RST_BYTE 8'h00
`define BTC_RST_CLKSEL 3'h0
`define BTC_HSRAM_BASE 8'h80

// ----------------------------------------------------------------
// instruction lengths in bytes
// ----------------------------------------------------------------
`define BTC_LEN_1 8'h01
`define BTC_LEN_2 8'h02
`define BTC_LEN_3 8'h03
`define BTC_LEN_4 8'h04

// ----------------------------------------------------------------
// instruction cycle counts (cpu clock periods)
// ----------------------------------------------------------------
`define BTC_CYC_2 4'h2
`define BTC_CYC_6 4'h6
`define BTC_CYC_8 4'h8
`define BTC_CYC_9 4'h9
`define BTC_CYC_10 4'ha
`define BTC_CYC_11 4'hb
`define BTC_CYC_12 4'hc

`endif

// ==== logic/btc_pkg.sv ====
// types of the bit-test branch and cpu control execution unit
// assumes btc_defines.svh is on the include path
package btc_pkg;

	// ----------------------------------------------------------------
	// operation codes written to the instruction register
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		BTC_OP_NOP = 4'h0,
		BTC_OP_BIT_TRUE = 4'h1, // branch_if_bit_true
		BTC_OP_BIT_FALSE = 4'h2, // branch_if_bit_false
		BTC_OP_TEST_CLR = 4'h3, // test_clear_and_branch
		BTC_OP_DEC_B = 4'h4, // decrement_branch_nonzero on b
		BTC_OP_DEC_C = 4'h5, // decrement_branch_nonzero on c
		BTC_OP_DEC_MEM = 4'h6, // decrement_branch_nonzero on short-direct byte
		BTC_OP_INT_EN = 4'h7, // interrupt_enable_instr
		BTC_OP_INT_MASK = 4'h8, // interrupt_mask_instr
		BTC_OP_HALT = 4'h9,
		BTC_OP_STOP = 4'ha
	} btc_op_e;

	// ----------------------------------------------------------------
	// bit operand sources
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		BTC_K_SADDR = 3'h0,
		BTC_K_SFR = 3'h1,
		BTC_K_ACC = 3'h2,
		BTC_K_FLAGS = 3'h3,
		BTC_K_PTR = 3'h4 // memory_pointer_pair addressed
	} btc_kind_e;

	// ----------------------------------------------------------------
	// sequencer states, gray along idle-read-wait
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		BTC_ST_IDLE = 2'b00,
		BTC_ST_READ = 2'b01,
		BTC_ST_WAIT = 2'b11,
		BTC_ST_STANDBY = 2'b10
	} btc_state_e;

endpackage : btc_pkg

// ==== logic/btc_data_ram.sv ====
// data memory of the execution unit: one core port, one software port
// assumes the core and software never write the same cycle on purpose
`timescale 1ns/100ps
module btc_data_ram #(
	parameter int AW = 8,
	parameter int DW = 8
) (
	// clock
	input wire logic pclk,
	// core port
	input wire logic [AW-1:0] core_addr,
	input wire logic core_we,
	input wire logic [DW-1:0] core_wdata,
	output logic [DW-1:0] core_q,
	// software port
	input wire logic [AW-1:0] sw_addr,
	input wire logic sw_we,
	input wire logic [DW-1:0] sw_wdata,
	output logic [DW-1:0] sw_q
);

	logic [DW-1:0] mem [0:(1<<AW)-1];

	// writes, the core port wins a collision
	always_ff @(posedge pclk) begin
		if (core_we) begin
			mem[core_addr] <= core_wdata;
		end else if (sw_we) begin
			mem[sw_addr] <= sw_wdata;
		end
	end

	// registered reads
	always_ff @(posedge pclk) begin
		core_q <= mem[core_addr];
		sw_q <= mem[sw_addr];
	end

endmodule : btc_data_ram

// ==== logic/btc_cycle_timer.sv ====
// instruction cycle timer: cpu clock enable divider plus cycle down counter
// assumes start is a one-cycle pulse and count is at least one
`timescale 1ns/100ps
module btc_cycle_timer #(
	parameter int CW = 4,
	parameter int SW = 3,
	parameter int DW = 8
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// control
	input wire logic start,
	input wire logic [CW-1:0] count,
	input wire logic [SW-1:0] sel,
	// status
	output logic busy,
	output logic done
);

	logic run_reg;
	logic [CW-1:0] left_reg;
	logic [DW-1:0] div_reg;
	logic [DW-1:0] div_limit;
	logic cpu_tick;

	// one cpu clock period is 2**sel pclk cycles
	assign div_limit = DW'(({{(DW-1){1'b0}}, 1'b1} << sel) - 1'b1);
	assign cpu_tick = run_reg && (div_reg == div_limit);
	assign busy = run_reg;
	assign done = cpu_tick && (left_reg == CW'(1));

	// divider and period counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_reg <= 1'b0;
			left_reg <= '0;
			div_reg <= '0;
		end else if (start) begin
			run_reg <= 1'b1;
			left_reg <= count;
			div_reg <= '0;
		end else if (cpu_tick) begin
			div_reg <= '0;
			left_reg <= left_reg - 1'b1;
			run_reg <= !done;
		end else if (run_reg) begin
			div_reg <= div_reg + 1'b1;
		end
	end

endmodule : btc_cycle_timer

// ==== logic/btc_exec_core.sv ====
// execution unit for bit-test branches, decrement loops and cpu control
// assumes an apb master; programs run from internal rom, so counts apply
// How it works
// - bit-true branch: pc plus length plus offset
// - bit-false branch taken only when bit zero
// - status-word test-clear branches then clears bit
// - pointer memory bit: branch, write bit zero
// - pointer bit tests: 10 or 11 cycles, test-clear 10 or 12
// - b/c decrement, branch nonzero, 6 cycles
// - memory byte decrement, branch nonzero, 8/10
// - interrupt enable sets master flag, 6 cycles
// - interrupt mask clears master flag, 6 cycles
// - one count is one selected cpu clock
// - slow count outside high-speed ram area
// - counts hold for internal rom execution
// - fast count for high-speed ram, no access
//
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
`include "btc_defines.svh"
module btc_exec_core
	import btc_pkg::*;
#(
	parameter logic [7:0] HSRAM_BASE = `BTC_HSRAM_BASE
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	// core state
	output logic interrupt_master_flag,
	output logic halt_mode,
	output logic stop_mode,
	output logic busy
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	btc_state_e state_reg;
	btc_state_e state_next;
	logic [31:0] instr_reg;
	logic [15:0] pc_reg;
	logic [7:0] a_reg;
	logic [7:0] b_reg;
	logic [7:0] c_reg;
	logic [7:0] flags_reg;
	logic [15:0] ptr_reg;
	logic [2:0] clksel_reg;
	logic [7:0] maddr_reg;
	logic int_en_reg;
	logic halt_reg;
	logic stop_reg;
	logic taken_reg;
	logic fast_reg;
	logic [3:0] cyc_reg;
	logic [31:0] rdata_reg;
	logic mdata_rd_reg;

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	logic setup;
	logic access;
	logic wr;
	logic idle;
	logic hit_instr, hit_pc, hit_regs, hit_ptr, hit_stat;
	logic hit_wake, hit_maddr, hit_mdata, hit_clksel, hit_any;
	logic wr_ok;

	// address match and write qualification
	assign setup = psel && !penable;
	assign access = psel && penable;
	assign wr = access && pwrite;
	assign idle = (state_reg == BTC_ST_IDLE);
	assign hit_instr = (paddr == `BTC_OFS_INSTR);
	assign hit_pc = (paddr == `BTC_OFS_PC);
	assign hit_regs = (paddr == `BTC_OFS_REGS);
	assign hit_ptr = (paddr == `BTC_OFS_PTR);
	assign hit_stat = (paddr == `BTC_OFS_STAT);
	assign hit_wake = (paddr == `BTC_OFS_WAKE);
	assign hit_maddr = (paddr == `BTC_OFS_MADDR);
	assign hit_mdata = (paddr == `BTC_OFS_MDATA);
	assign hit_clksel = (paddr == `BTC_OFS_CLKSEL);
	assign hit_any = hit_instr | hit_pc | hit_regs | hit_ptr | hit_stat
		| hit_wake | hit_maddr | hit_mdata | hit_clksel;
	assign wr_ok = wr && idle; // writes refused while executing
	assign pready = 1'b1;
	assign pslverr = access && !hit_any;

	// ----------------------------------------------------------------
	// instruction decode
	// ----------------------------------------------------------------
	btc_op_e op;
	btc_kind_e kind;
	logic [2:0] bitn;
	logic [7:0] disp;
	logic [7:0] saddr;
	logic [7:0] mem_addr;
	logic [7:0] mem_q;
	logic [7:0] src;
	logic bit_val;
	logic bit_op;
	logic mem_kind;
	logic fast;
	logic [7:0] len;
	logic [3:0] cyc;
	logic taken;
	logic [7:0] cleared;
	logic [7:0] dec_b, dec_c, dec_m;
	logic [15:0] pc_seq;
	logic [15:0] pc_target;
	logic commit;
	logic mem_we;
	logic [7:0] mem_wdata;
	logic timer_done;
	logic [7:0] sw_q;

	assign op = btc_op_e'(instr_reg[`BTC_F_OP]);
	assign kind = btc_kind_e'(instr_reg[`BTC_F_KIND]);
	assign bitn = instr_reg[`BTC_F_BIT];
	assign disp = instr_reg[`BTC_F_DISP];
	assign saddr = instr_reg[`BTC_F_SADDR];

	// operand fetch: accumulator, status word or a data memory byte
	assign bit_op = (op == BTC_OP_BIT_TRUE) || (op == BTC_OP_BIT_FALSE)
		|| (op == BTC_OP_TEST_CLR);
	assign mem_kind = (kind == BTC_K_SADDR) || (kind == BTC_K_SFR) || (kind == BTC_K_PTR);
	assign mem_addr = (kind == BTC_K_PTR) ? ptr_reg[7:0] : saddr;
	assign src = (kind == BTC_K_ACC) ? a_reg : (kind == BTC_K_FLAGS) ? flags_reg : mem_q;
	assign bit_val = src[bitn];
	assign cleared = src & ~(8'h01 << bitn);

	// high-speed area, or no data access at all, takes the first count
	assign fast = (bit_op && (kind == BTC_K_SADDR || kind == BTC_K_PTR)
		|| op == BTC_OP_DEC_MEM) ? (mem_addr >= HSRAM_BASE) : 1'b1;

	// length and cycle table
	always_comb begin
		len = `BTC_LEN_1;
		cyc = `BTC_CYC_2;
		unique case (op)
			BTC_OP_BIT_TRUE: begin
				len = (kind == BTC_K_SFR) ? `BTC_LEN_4 : `BTC_LEN_3;
				unique case (kind)
					BTC_K_SADDR: cyc = fast ? `BTC_CYC_8 : `BTC_CYC_9;
					BTC_K_SFR: cyc = `BTC_CYC_11;
					BTC_K_ACC: cyc = `BTC_CYC_8;
					BTC_K_FLAGS: cyc = `BTC_CYC_9;
					default: cyc = fast ? `BTC_CYC_10 : `BTC_CYC_11;
				endcase
			end
			BTC_OP_BIT_FALSE: begin
				len = (kind == BTC_K_ACC || kind == BTC_K_PTR) ? `BTC_LEN_3 : `BTC_LEN_4;
				unique case (kind)
					BTC_K_SADDR: cyc = fast ? `BTC_CYC_10 : `BTC_CYC_11;
					BTC_K_SFR: cyc = `BTC_CYC_11;
					BTC_K_ACC: cyc = `BTC_CYC_8;
					BTC_K_FLAGS: cyc = `BTC_CYC_11;
					default: cyc = fast ? `BTC_CYC_10 : `BTC_CYC_11;
				endcase
			end
			BTC_OP_TEST_CLR: begin
				len = (kind == BTC_K_ACC || kind == BTC_K_PTR) ? `BTC_LEN_3 : `BTC_LEN_4;
				unique case (kind)
					BTC_K_SADDR: cyc = fast ? `BTC_CYC_10 : `BTC_CYC_12;
					BTC_K_SFR: cyc = `BTC_CYC_12;
					BTC_K_ACC: cyc = `BTC_CYC_8;
					BTC_K_FLAGS: cyc = `BTC_CYC_12;
					default: cyc = fast ? `BTC_CYC_10 : `BTC_CYC_12;
				endcase
			end
			BTC_OP_DEC_B, BTC_OP_DEC_C: begin
				len = `BTC_LEN_2;
				cyc = `BTC_CYC_6;
			end
			BTC_OP_DEC_MEM: begin
				len = `BTC_LEN_3;
				cyc = fast ? `BTC_CYC_8 : `BTC_CYC_10;
			end
			BTC_OP_INT_EN, BTC_OP_INT_MASK, BTC_OP_HALT, BTC_OP_STOP: begin
				len = `BTC_LEN_2;
				cyc = `BTC_CYC_6;
			end
			default: begin
				len = `BTC_LEN_1;
				cyc = `BTC_CYC_2;
			end
		endcase
	end

	// branch condition, decrement happens before the zero test
	assign dec_b = b_reg - 8'h01;
	assign dec_c = c_reg - 8'h01;
	assign dec_m = mem_q - 8'h01;
	assign taken = (op == BTC_OP_BIT_TRUE) ? bit_val
		: (op == BTC_OP_BIT_FALSE) ? !bit_val
		: (op == BTC_OP_TEST_CLR) ? bit_val
		: (op == BTC_OP_DEC_B) ? (dec_b != 8'h00)
		: (op == BTC_OP_DEC_C) ? (dec_c != 8'h00)
		: (op == BTC_OP_DEC_MEM) ? (dec_m != 8'h00)
		: 1'b0;

	// signed offset from the byte after the instruction
	assign pc_seq = pc_reg + {8'h00, len};
	assign pc_target = taken ? (pc_seq + {{8{disp[7]}}, disp}) : pc_seq;

	// memory write-back at the end of the instruction
	assign commit = (state_reg == BTC_ST_WAIT) && timer_done;
	assign mem_we = commit && ((op == BTC_OP_DEC_MEM)
		|| (op == BTC_OP_TEST_CLR && taken && mem_kind));
	assign mem_wdata = (op == BTC_OP_DEC_MEM) ? dec_m : cleared;

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			BTC_ST_IDLE: if (wr && hit_instr) state_next = BTC_ST_READ;
			BTC_ST_READ: state_next = BTC_ST_WAIT;
			BTC_ST_WAIT: begin
				if (commit) begin
					state_next = (op == BTC_OP_HALT || op == BTC_OP_STOP)
						? BTC_ST_STANDBY : BTC_ST_IDLE;
				end
			end
			BTC_ST_STANDBY: if (wr && hit_wake) state_next = BTC_ST_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= BTC_ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// ----------------------------------------------------------------
	// architectural registers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pc_reg <= `BTC_RST_PC;
			a_reg <= `BTC_RST_BYTE;
			b_reg <= `BTC_RST_BYTE;
			c_reg <= `BTC_RST_BYTE;
			flags_reg <= `BTC_RST_BYTE;
		end else if (commit) begin
			pc_reg <= pc_target;
			if (op == BTC_OP_DEC_B) b_reg <= dec_b;
			if (op == BTC_OP_DEC_C) c_reg <= dec_c;
			if (op == BTC_OP_TEST_CLR && taken && kind == BTC_K_ACC) a_reg <= cleared;
			if (op == BTC_OP_TEST_CLR && taken && kind == BTC_K_FLAGS) flags_reg <= cleared;
		end else if (wr_ok && hit_pc) begin
			pc_reg <= pwdata[15:0];
		end else if (wr_ok && hit_regs) begin
			a_reg <= pwdata[`BTC_F_A];
			b_reg <= pwdata[`BTC_F_B];
			c_reg <= pwdata[`BTC_F_C];
			flags_reg <= pwdata[`BTC_F_FLAGS];
		end
	end

	// interrupt master flag and standby modes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_en_reg <= 1'b0;
			halt_reg <= 1'b0;
			stop_reg <= 1'b0;
		end else if (commit) begin
			if (op == BTC_OP_INT_EN) int_en_reg <= 1'b1;
			if (op == BTC_OP_INT_MASK) int_en_reg <= 1'b0;
			halt_reg <= (op == BTC_OP_HALT);
			stop_reg <= (op == BTC_OP_STOP);
		end else if (wr && hit_wake) begin
			halt_reg <= 1'b0;
			stop_reg <= 1'b0;
		end
	end

	// software set-up registers and execution record
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			instr_reg <= 32'h00000000;
			ptr_reg <= 16'h0000;
			clksel_reg <= `BTC_RST_CLKSEL;
			maddr_reg <= `BTC_RST_BYTE;
			taken_reg <= 1'b0;
			fast_reg <= 1'b0;
			cyc_reg <= 4'h0;
		end else begin
			if (wr_ok && hit_instr) instr_reg <= pwdata;
			if (wr_ok && hit_ptr) ptr_reg <= pwdata[`BTC_F_PTR];
			if (wr_ok && hit_clksel) clksel_reg <= pwdata[`BTC_F_CLKSEL];
			if (wr_ok && hit_maddr) maddr_reg <= pwdata[7:0];
			if (commit) begin
				taken_reg <= taken;
				fast_reg <= fast;
				cyc_reg <= cyc;
			end
		end
	end

	// read data captured in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_reg <= 32'h00000000;
			mdata_rd_reg <= 1'b0;
		end else if (setup) begin
			mdata_rd_reg <= hit_mdata;
			rdata_reg <= hit_instr ? instr_reg
				: hit_pc ? {16'h0000, pc_reg}
				: hit_regs ? {flags_reg, c_reg, b_reg, a_reg}
				: hit_ptr ? {16'h0000, ptr_reg}
				: hit_stat ? {20'h00000, cyc_reg, 2'b00, fast_reg, taken_reg,
					stop_reg, halt_reg, int_en_reg, !idle}
				: hit_maddr ? {24'h000000, maddr_reg}
				: hit_clksel ? {29'h00000000, clksel_reg}
				: 32'h00000000;
		end
	end

	assign prdata = mdata_rd_reg ? {24'h000000, sw_q} : rdata_reg;
	assign interrupt_master_flag = int_en_reg;
	assign halt_mode = halt_reg;
	assign stop_mode = stop_reg;
	assign busy = !idle;

	// ----------------------------------------------------------------
	// cycle timer and data memory
	// ----------------------------------------------------------------

	// counts in periods of the selected cpu clock
	btc_cycle_timer #(.CW(4), .SW(3), .DW(8)) u_timer (
		.pclk(pclk),
		.presetn(presetn),
		.start(state_reg == BTC_ST_READ),
		.count(cyc),
		.sel(clksel_reg),
		.busy(),
		.done(timer_done)
	);

	btc_data_ram #(.AW(8), .DW(8)) u_ram (
		.pclk(pclk),
		.core_addr(mem_addr),
		.core_we(mem_we),
		.core_wdata(mem_wdata),
		.core_q(mem_q),
		.sw_addr(maddr_reg),
		.sw_we(wr_ok && hit_mdata),
		.sw_wdata(pwdata[7:0]),
		.sw_q(sw_q)
	);

endmodule : btc_exec_core

// ==== tb/btc_apb_host.sv ====
// apb master standing in for software on the register bus
// assumes one transfer at a time and a slave that answers at some point
`timescale 1ns/100ps
module btc_apb_host (
	// clock
	input wire logic pclk,
	// apb master side
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata,
	input wire logic pready,
	input wire logic [31:0] prdata,
	input wire logic pslverr
);
	// idle bus from time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
	end

	// setup cycle, then access held until pready is seen high
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
endmodule : btc_apb_host

// ==== tb/btc_exec_assertions.sv ====
// checker of the execution unit: bus answers, flag timing, run lengths
// assumes it is bound to btc_exec_core and sees only its ports
`timescale 1ns/100ps
module btc_exec_checker (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	// core state
	input wire logic interrupt_master_flag,
	input wire logic halt_mode,
	input wire logic stop_mode,
	input wire logic busy
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// --------
	// helper: launch, cpu clock select, busy length
	// --------
	wire launch = psel && penable && pwrite && paddr == 12'h000 && !busy;
	wire sel_wr = psel && penable && pwrite && paddr == 12'h020 && !busy;
	logic [3:0] op_reg;
	logic [2:0] sel_reg;
	logic [11:0] run_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			op_reg <= 4'h0;
			sel_reg <= 3'h0;
			run_reg <= 12'h000;
		end else begin
			op_reg <= launch ? pwdata[3:0] : op_reg;
			sel_reg <= sel_wr ? pwdata[2:0] : sel_reg;
			run_reg <= launch ? 12'h000 : run_reg + {11'h0, busy};
		end
	end

	// --------
	// properties
	// --------
	sequence s_run; busy [*3]; endsequence
	sequence s_commit; $fell(busy); endsequence
	property p_launch; launch |=> busy; endproperty
	property p_min; $rose(busy) |-> s_run; endproperty
	property p_fixed;
		s_commit ##0 (op_reg inside {4'h4, 4'h5, 4'h7, 4'h8}) |-> run_reg == (12'd6 << sel_reg) + 12'd1;
	endproperty
	property p_int_set; $rose(interrupt_master_flag) |-> s_commit ##0 op_reg == 4'h7; endproperty
	property p_int_clr; $fell(interrupt_master_flag) |-> s_commit ##0 op_reg == 4'h8; endproperty
	property p_halt; halt_mode |-> busy && !stop_mode && op_reg == 4'h9; endproperty
	property p_stop; $rose(stop_mode) |-> $past(busy) && op_reg == 4'ha; endproperty
	property p_wake; psel && penable && pwrite && paddr == 12'h014 |=> !halt_mode && !stop_mode;
	endproperty
	property p_err;
		pslverr |-> psel && penable && (paddr > 12'h020 || paddr[1:0] != 2'b00);
	endproperty

	a_launch: assert property (p_launch)
		else $error("instruction write did not start a run");
	a_min: assert property (p_min)
		else $error("run shorter than two cpu cycles");
	a_fixed: assert property (p_fixed)
		else $error("six cycle run has wrong length");
	a_int_set: assert property (p_int_set)
		else $error("interrupt flag set outside enable commit");
	a_int_clr: assert property (p_int_clr)
		else $error("interrupt flag cleared outside mask commit");
	a_halt: assert property (p_halt)
		else $error("halt mode without halt instruction");
	a_stop: assert property (p_stop)
		else $error("stop mode without stop instruction");
	a_wake: assert property (p_wake)
		else $error("wake write left standby set");
	a_err: assert property (p_err)
		else $error("error answer outside unmapped access");
endmodule : btc_exec_checker

bind btc_exec_core btc_exec_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.prdata(prdata), .pslverr(pslverr), .interrupt_master_flag(interrupt_master_flag),
	.halt_mode(halt_mode), .stop_mode(stop_mode), .busy(busy));

// ==== tb/bit_test_branch_cpu_control_exec_bench.sv ====
// self-checking bench of the execution unit: table of instructions, then edge cases
// assumes the apb host model and the bound checker
`timescale 1ns/100ps
`include "btc_defines.svh"
module bit_test_branch_cpu_control_exec_bench;
	typedef struct packed {
		logic [31:0] regs;
		logic [7:0] ptr;
		logic [7:0] mem;
		logic [31:0] instr;
		logic [15:0] pc;
		logic [31:0] rx;
		logic [7:0] mx;
		logic [3:0] cyc;
		logic ien;
	} btc_row_s;
	// regs, ptr, mem, instr, expected pc, regs, mem, cycles, ien; pc starts at 0100
	btc_row_s rows [18] = '{
		'{32'h0, 8'h90, 8'h08, 32'h90100301, 16'h0113, 32'h0, 8'h08, 4'h8, 1'b0},
		'{32'h0, 8'h90, 8'h01, 32'h90fe0011, 16'h0102, 32'h0, 8'h01, 4'hb, 1'b0},
		'{32'h0, 8'h40, 8'h80, 32'h00050741, 16'h0108, 32'h0, 8'h80, 4'hb, 1'b0},
		'{32'h0, 8'h90, 8'h00, 32'h00050741, 16'h0103, 32'h0, 8'h00, 4'ha, 1'b0},
		'{32'h0, 8'h90, 8'h08, 32'h90100302, 16'h0104, 32'h0, 8'h08, 4'ha, 1'b0},
		'{32'h0, 8'h90, 8'h08, 32'h00800222, 16'h0083, 32'h0, 8'h08, 4'h8, 1'b0},
		'{32'h0, 8'h90, 8'h00, 32'h00040032, 16'h0108, 32'h0, 8'h00, 4'hb, 1'b0},
		'{32'h01000000, 8'h90, 8'h00, 32'h00100033, 16'h0114, 32'h0, 8'h00, 4'hc, 1'b0},
		'{32'h0, 8'h90, 8'h04, 32'h00200243, 16'h0123, 32'h0, 8'h00, 4'ha, 1'b0},
		'{32'h00000100, 8'h90, 8'h00, 32'h00100004, 16'h0102, 32'h0, 8'h00, 4'h6, 1'b0},
		'{32'h0, 8'h90, 8'h00, 32'h00100005, 16'h0112, 32'h00ff0000, 8'h00, 4'h6, 1'b0},
		'{32'h0, 8'h90, 8'h02, 32'h20100006, 16'h0113, 32'h0, 8'h01, 4'ha, 1'b0},
		'{32'h0, 8'h90, 8'h01, 32'h90100006, 16'h0103, 32'h0, 8'h00, 4'h8, 1'b0},
		'{32'h0, 8'h90, 8'h00, 32'h00000007, 16'h0102, 32'h0, 8'h00, 4'h6, 1'b1},
		'{32'h0, 8'h90, 8'h00, 32'h00000008, 16'h0102, 32'h0, 8'h00, 4'h6, 1'b0},
		'{32'h0, 8'h90, 8'h00, 32'h00000000, 16'h0101, 32'h0, 8'h00, 4'h2, 1'b0},
		'{32'h00000010, 8'h90, 8'h00, 32'h00100423, 16'h0113, 32'h0, 8'h00, 4'h8, 1'b0},
		'{32'h0, 8'h90, 8'h81, 32'h20100703, 16'h0114, 32'h0, 8'h01, 4'hc, 1'b0}};
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel, penable, pwrite, pready, pslverr, interrupt_master_flag, halt_mode, stop_mode, busy;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic e;
	btc_row_s r;
	int err_count = 0;
	int check_count = 0;
	int cyc_count = 0;

	// clock, design and bus master
	always #12.5 pclk = ~pclk;
	btc_exec_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .interrupt_master_flag(interrupt_master_flag),
		.halt_mode(halt_mode), .stop_mode(stop_mode), .busy(busy));
	btc_apb_host u_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));

	// --------
	// compare, bus and closing tasks
	// --------
	task automatic chk_word(input string n, input logic [31:0] x, input logic [31:0] g);
		check_count++;
		if (g !== x) begin
			err_count++;
			$display("Error %s expected %h seen %h", n, x, g);
		end
	endtask : chk_word
	task automatic chk_bit(input string n, input logic x, input logic g);
		check_count++;
		if (g !== x) begin
			err_count++;
			$display("Error %s expected %b seen %b", n, x, g);
		end
	endtask : chk_bit
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] v;
		logic f;
		u_host.xfer(1'b1, a, d, v, f);
	endtask : wr
	task automatic rd(input logic [11:0] a, output logic [31:0] v);
		logic f;
		u_host.xfer(1'b0, a, 32'h0, v, f);
	endtask : rd
	task automatic wait_idle();
		logic [31:0] v;
		v = 32'h1;
		for (int k = 0; k < 300 && v[0] !== 1'b0; k++) rd(`BTC_OFS_STAT, v);
	endtask : wait_idle
	task automatic print_verdict();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : print_verdict

	// hang guard
	always @(posedge pclk) begin
		cyc_count <= cyc_count + 1;
		if (cyc_count == 20000) begin
			err_count++;
			print_verdict();
		end
	end

	// --------
	// main sequence
	// --------
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd(`BTC_OFS_STAT, q);
		chk_word("stat reset", 32'h0, q);
		rd(`BTC_OFS_PC, q);
		chk_word("pc reset", 32'h0, q);
		// table of instructions
		for (int i = 0; i < 18; i++) begin
			r = rows[i];
			wr(`BTC_OFS_REGS, r.regs);
			wr(`BTC_OFS_PTR, {24'h0, r.ptr});
			wr(`BTC_OFS_MADDR, {24'h0, (r.instr[6:4] == 3'h4) ? r.ptr : r.instr[31:24]});
			wr(`BTC_OFS_MDATA, {24'h0, r.mem});
			wr(`BTC_OFS_PC, 32'h0100);
			wr(`BTC_OFS_INSTR, r.instr);
			wait_idle();
			rd(`BTC_OFS_PC, q);
			chk_word("pc", {16'h0, r.pc}, q);
			rd(`BTC_OFS_REGS, q);
			chk_word("regs", r.rx, q);
			rd(`BTC_OFS_MDATA, q);
			chk_word("mem", {24'h0, r.mx}, q);
			rd(`BTC_OFS_STAT, q);
			chk_word("cycles", {28'h0, r.cyc}, {28'h0, q[`BTC_F_CYC]});
			chk_bit("int flag", r.ien, interrupt_master_flag);
		end
		// unmapped word answers with error and zero data
		u_host.xfer(1'b0, 12'h040, 32'h0, q, e);
		chk_bit("slverr", 1'b1, e);
		chk_word("unmapped", 32'h0, q);
		// halved cpu clock; a pc write while busy is dropped
		wr(`BTC_OFS_CLKSEL, 32'h1);
		wr(`BTC_OFS_PC, 32'h0100);
		wr(`BTC_OFS_INSTR, 32'h00000007);
		wr(`BTC_OFS_PC, 32'h5555);
		wait_idle();
		rd(`BTC_OFS_PC, q);
		chk_word("pc busy", 32'h0102, q);
		wr(`BTC_OFS_CLKSEL, 32'h0);
		// halt then stop, each left by a wake write
		for (int m = 0; m < 2; m++) begin
			wr(`BTC_OFS_PC, 32'h0100);
			wr(`BTC_OFS_INSTR, 32'h9 + m);
			for (int k = 0; k < 50 && (halt_mode | stop_mode) !== 1'b1; k++) @(posedge pclk);
			chk_bit("halt", m == 0, halt_mode);
			chk_bit("stop", m == 1, stop_mode);
			chk_bit("busy", 1'b1, busy);
			wr(`BTC_OFS_WAKE, 32'h1);
			@(posedge pclk);
			chk_bit("woken", 1'b0, halt_mode | stop_mode | busy);
			rd(`BTC_OFS_PC, q);
			chk_word("pc standby", 32'h0102, q);
		end
		print_verdict();
	end
endmodule : bit_test_branch_cpu_control_exec_bench
